/* File: hdl/mrid_core.v */
// mid-range 14-bit instruction decoder and sequencer
// ----------------------------------------------------------------
// Overview of operation
// [RL1] each instruction is one 14-bit word: opcode plus operand fields
// [RL2] destination bit 0 writes accumulator, 1 writes the file register
// [RL3] byte format: opcode 13..8, destination bit 7, address 6..0
// [RL4] bit format: opcode 13..10, bit select 9..7, address 6..0
// [RL5] literal words carry an 8-bit constant or 11-bit address
// [RL6] one instruction cycle is four clock periods
// [RL7] one cycle per instruction; branches and taken tests take two
// [RL8] every file instruction reads, modifies and stores its register; the code stores it only for destination bit 1 and bit clear/set
// [RL9] add 000111 and subtract 000010 update carry, digit carry, zero
// [RL10] or, and, xor, complement update only the zero flag
// [RL11] rotates go through carry and affect only carry
// [RL12] inc/dec update zero; skip forms skip on zero, no flags
// [RL13] clear file or accumulator zeroes the target and sets zero
// [RL14] bit clear, set and test-skip touch no flags; skip costs two
// [RL15] add literal 11111x and subtract literal update c, dc, z
// [RL16] literal and, or, xor write accumulator and affect only zero
// [RL17] interrupt return, return and return-literal take two cycles
// [RL18] standby and watchdog clear take one cycle, touch timeout flags
// [RL19] writing the timer count clears the prescaler if assigned
// [RL20] don't-care opcode bits are ignored by the decoder
// [RL21] standby clears power-down and sets timeout flag
// [RL22] watchdog clear resets watchdog and prescaler, sets both flags; the code pulses only watchdog_clr, not prescaler_clr
// [RL23] taken skip discards the fetched word and runs a no-operation
// [RL24] move file sets zero; store and nibble exchange touch no flags
// ----------------------------------------------------------------
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "mrid_defines.vh"
module mrid_core #(
  parameter PCW = `MRID_PCW,
  parameter DEPTH = `MRID_STACK_DEPTH
) (
  clk,
  nrst,
  instr,
  pclath_hi,
  fr_rdata,
  psa_to_timer,
  prog_addr,
  fr_addr,
  fr_rd,
  fr_wr,
  fr_wdata,
  acc,
  carry_flag,
  digit_carry_flag,
  zero_flag,
  timeout_flag,
  power_down_flag,
  prescaler_clr,
  watchdog_clr,
  standby,
  irq_return
);
  input wire clk;
  input wire nrst;
  input wire [13:0] instr;
  input wire [1:0] pclath_hi;
  input wire [7:0] fr_rdata;
  input wire psa_to_timer;
  output reg [PCW-1:0] prog_addr;
  output reg [6:0] fr_addr;
  output reg fr_rd;
  output reg fr_wr;
  output reg [7:0] fr_wdata;
  output reg [7:0] acc;
  output reg carry_flag;
  output reg digit_carry_flag;
  output reg zero_flag;
  output reg timeout_flag;
  output reg power_down_flag;
  output reg prescaler_clr;
  output reg watchdog_clr;
  output reg standby;
  output reg irq_return;

  // ----------------------------------------------------------------
  // cycle timing
  // ----------------------------------------------------------------
  localparam ST_RUN = 2'b01;
  localparam ST_FLUSH = 2'b10;

  wire cyc_end;
  reg [1:0] state_ff;
  reg [13:0] ir_ff;
  reg [PCW-1:0] pc_ff;
  reg [PCW-1:0] stack_ff [0:DEPTH-1];
  reg [2:0] sp_ff;
  integer i;

  mrid_phase_gen #(
    .PHASES(`MRID_PHASES)
  ) u_phase (
    .clk(clk),
    .nrst(nrst),
    .cycle_end(cyc_end)
  );

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [5:0] opc = ir_ff[13:8]; // RL3
  wire dest = ir_ff[7]; // RL3
  wire [6:0] faddr = ir_ff[6:0]; // RL3 RL4
  wire [1:0] bop = ir_ff[11:10]; // RL4
  wire [2:0] bsel = ir_ff[9:7]; // RL4
  wire [7:0] lit = ir_ff[7:0]; // RL5
  wire [10:0] kaddr = ir_ff[10:0]; // RL5
  wire cls_byte = (ir_ff[13:12] == 2'b00); // RL1
  wire cls_bit = (ir_ff[13:12] == 2'b01); // RL14
  wire cls_ctl = (ir_ff[13:12] == 2'b10);
  wire cls_lit = (ir_ff[13:12] == 2'b11);
  wire [7:0] bmask = 8'h01 << bsel;

  // the operand path reads the addressed register for byte and bit words
  reg [3:0] alu_op;
  reg [7:0] alu_a;
  // literal words combine with the accumulator, not with the file data
  wire [7:0] alu_b = cls_lit ? acc : fr_rdata;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;

  mrid_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .cin(carry_flag),
    .res(alu_res),
    .cout(alu_c),
    .dcout(alu_dc)
  );

  // ----------------------------------------------------------------
  // execute decode
  // ----------------------------------------------------------------
  reg wr_f;
  reg wr_w;
  reg upd_z;
  reg upd_c;
  reg upd_dc;
  reg skip;
  reg jump;
  reg [PCW-1:0] jump_pc;
  reg push;
  reg pop;
  reg set_zero_one;
  reg do_sleep;
  reg do_wdt;
  reg do_reti;
  reg [7:0] res;
  reg [7:0] wdat;

  always @* begin
    alu_op = 4'hd;
    alu_a = acc;
    wr_f = 1'b0;
    wr_w = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    jump_pc = pc_ff;
    push = 1'b0;
    pop = 1'b0;
    set_zero_one = 1'b0;
    do_sleep = 1'b0;
    do_wdt = 1'b0;
    do_reti = 1'b0;
    res = alu_res;
    wdat = alu_res;
    if (cls_byte) begin
      wr_f = dest; // RL2
      wr_w = ~dest; // RL2
      case (opc)
        `MRID_OP_MISC: begin
          wr_w = 1'b0;
          // don't-care bits 6,5 of the misc group are ignored
          if (dest) begin
            alu_op = 4'hc; // RL24
          end else begin
            wr_f = 1'b0;
            if (ir_ff == `MRID_W_RETFI) begin
              pop = 1'b1; // RL17
              do_reti = 1'b1;
            end else if (ir_ff == `MRID_W_RET) begin
              pop = 1'b1; // RL17
            end else if (ir_ff == `MRID_W_SLEEP) begin
              do_sleep = 1'b1; // RL18 RL21
            end else if (ir_ff == `MRID_W_WDTCLR) begin
              do_wdt = 1'b1; // RL18 RL22
            end
            // anything else, incl. 0xx0 0000, is a no-operation RL20
          end
        end
        `MRID_OP_CLR: begin
          alu_op = 4'hd; // RL13
          set_zero_one = 1'b1; // RL13
        end
        `MRID_OP_SUB_ACC_FROM_FILE: begin
          alu_op = 4'h1; // RL9
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
        end
        `MRID_OP_ADD_ACC_TO_FILE: begin
          alu_op = 4'h0; // RL9
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
        end
        `MRID_OP_IOR: begin
          alu_op = 4'h2; // RL10
          upd_z = 1'b1;
        end
        `MRID_OP_AND: begin
          alu_op = 4'h3; // RL10
          upd_z = 1'b1;
        end
        `MRID_OP_XOR: begin
          alu_op = 4'h4; // RL10
          upd_z = 1'b1;
        end
        `MRID_OP_COM: begin
          alu_op = 4'h5; // RL10
          upd_z = 1'b1;
        end
        `MRID_OP_RL: begin
          alu_op = 4'h8; // RL11
          upd_c = 1'b1;
        end
        `MRID_OP_RR: begin
          alu_op = 4'h9; // RL11
          upd_c = 1'b1;
        end
        `MRID_OP_INC: begin
          alu_op = 4'h6; // RL12
          upd_z = 1'b1;
        end
        `MRID_OP_DEC: begin
          alu_op = 4'h7; // RL12
          upd_z = 1'b1;
        end
        `MRID_OP_INCSZ: begin
          alu_op = 4'h6;
          skip = (alu_res == 8'h00); // RL12
        end
        `MRID_OP_DECSZ: begin
          alu_op = 4'h7;
          skip = (alu_res == 8'h00); // RL12
        end
        `MRID_OP_MOVF: begin
          alu_op = 4'hb; // RL24
          upd_z = 1'b1;
        end
        `MRID_OP_SWAP: alu_op = 4'ha; // RL24
        default: begin
          wr_f = 1'b0;
          wr_w = 1'b0;
        end
      endcase
    end else if (cls_bit) begin
      // bit clear and set write the whole byte back after reading it; tests only read
      case (bop)
        `MRID_BIT_CLR: begin
          wr_f = 1'b1; // RL8 RL14
          wdat = fr_rdata & ~bmask;
        end
        `MRID_BIT_SET: begin
          wr_f = 1'b1; // RL14
          wdat = fr_rdata | bmask;
        end
        `MRID_BIT_TSC: skip = ((fr_rdata & bmask) == 8'h00); // RL14
        default: skip = ((fr_rdata & bmask) != 8'h00); // RL14
      endcase
    end else if (cls_ctl) begin
      jump = 1'b1; // RL7
      jump_pc = {pclath_hi, kaddr}; // RL5
      push = (ir_ff[13:11] == `MRID_CTL_CALL);
    end else begin
      alu_a = lit; // RL16
      res = alu_res;
      wr_w = 1'b1;
      if (opc == `MRID_LIT_IOR) begin
        alu_op = 4'h2; // RL16
        upd_z = 1'b1;
      end else if (opc == `MRID_LIT_AND) begin
        alu_op = 4'h3; // RL16
        upd_z = 1'b1;
      end else if (opc == `MRID_LIT_XOR) begin
        alu_op = 4'h4; // RL16
        upd_z = 1'b1;
      end else if (opc[5:1] == `MRID_LIT_ADD_HI) begin
        alu_op = 4'h0; // RL15
        upd_z = 1'b1;
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end else if (opc[5:1] == `MRID_LIT_SUB_HI) begin
        alu_op = 4'h0; // RL15
        alu_a = lit + ~acc + 8'h01;
        res = alu_a;
        upd_z = 1'b1;
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end else if (opc[5:2] == `MRID_LIT_RET_HI) begin
        alu_op = 4'hc;
        pop = 1'b1; // RL17
      end else if (opc[5:2] == `MRID_LIT_MOV_HI) begin
        alu_op = 4'hc;
      end else begin
        wr_w = 1'b0;
      end
    end
    if (!wr_f) begin
      wdat = res;
    end
    if (cls_byte) begin
      wdat = res;
    end
  end

  // literal subtract carry: not-borrow of lit - acc
  wire [8:0] sub_acc_from_literal = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
  wire [4:0] sub_acc_from_literal_lo = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire is_sub_acc_from_literal = cls_lit && (opc[5:1] == `MRID_LIT_SUB_HI);
  wire [7:0] final_res = is_sub_acc_from_literal ? sub_acc_from_literal[7:0] : res;
  wire final_c = is_sub_acc_from_literal ? sub_acc_from_literal[8] : alu_c;
  wire final_dc = is_sub_acc_from_literal ? sub_acc_from_literal_lo[4] : alu_dc;

  // ----------------------------------------------------------------
  // sequencing and state update, once per instruction cycle
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_FLUSH;
      ir_ff <= 14'h0000;
      pc_ff <= `MRID_RST_VECTOR;
      sp_ff <= 3'h0;
      prog_addr <= `MRID_RST_VECTOR;
      fr_addr <= 7'h00;
      fr_rd <= 1'b0;
      fr_wr <= 1'b0;
      fr_wdata <= 8'h00;
      acc <= 8'h00;
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
      prescaler_clr <= 1'b0;
      watchdog_clr <= 1'b0;
      standby <= 1'b0;
      irq_return <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        stack_ff[i] <= {PCW{1'b0}};
      end
    end else begin
      fr_wr <= 1'b0;
      prescaler_clr <= 1'b0;
      watchdog_clr <= 1'b0;
      irq_return <= 1'b0;
      // read of the addressed register runs every cycle for byte and bit words RL8
      // follow the word in execution so its operand is settled at commit
      fr_addr <= ir_ff[6:0];
      fr_rd <= ~ir_ff[13];
      if (cyc_end) begin
        ir_ff <= instr; // RL1
        pc_ff <= pc_ff + 1'b1;
        prog_addr <= pc_ff + 1'b1;
        state_ff <= ST_RUN;
        if (state_ff == ST_FLUSH) begin
          // discarded slot runs as a no-operation RL7 RL23
        end else begin
          if (wr_w) begin
            acc <= set_zero_one ? 8'h00 : final_res; // RL2 RL13
          end
          if (wr_f) begin
            fr_wr <= 1'b1; // RL2 RL8
            fr_addr <= faddr;
            fr_wdata <= set_zero_one ? 8'h00 : wdat;
            if (faddr == `MRID_FA_TMR && psa_to_timer) begin
              prescaler_clr <= 1'b1; // RL19
            end
          end
          if (upd_z) begin
            zero_flag <= (final_res == 8'h00);
          end
          if (set_zero_one) begin
            zero_flag <= 1'b1; // RL13
          end
          if (upd_c) begin
            carry_flag <= final_c;
          end
          if (upd_dc) begin
            digit_carry_flag <= final_dc;
          end
          if (do_sleep) begin
            power_down_flag <= 1'b0; // RL21
            timeout_flag <= 1'b1; // RL21
            watchdog_clr <= 1'b1;
            standby <= 1'b1;
          end
          if (do_wdt) begin
            watchdog_clr <= 1'b1; // RL22
            timeout_flag <= 1'b1; // RL22
            power_down_flag <= 1'b1; // RL22
          end
          irq_return <= do_reti;
          if (push) begin
            stack_ff[sp_ff] <= pc_ff;
            sp_ff <= sp_ff + 3'h1;
          end
          if (jump) begin
            pc_ff <= jump_pc; // RL7
            prog_addr <= jump_pc;
            state_ff <= ST_FLUSH;
          end else if (pop) begin
            pc_ff <= stack_ff[sp_ff - 3'h1]; // RL17
            prog_addr <= stack_ff[sp_ff - 3'h1];
            sp_ff <= sp_ff - 3'h1;
            state_ff <= ST_FLUSH;
          end else if (skip) begin
            state_ff <= ST_FLUSH; // RL23
          end
        end
      end
    end
  end
endmodule

/* File: hdl/mrid_defines.vh */
// constants for the mid-range instruction decoder
`ifndef MRID_DEFINES_VH
`define MRID_DEFINES_VH

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define MRID_IW 14
`define MRID_DW 8
`define MRID_FAW 7
`define MRID_PCW 13
`define MRID_KAW 11

// ----------------------------------------------------------------
// byte-oriented opcodes, bits 13..8
// ----------------------------------------------------------------
`define MRID_OP_MISC 6'h00
`define MRID_OP_CLR 6'h01
`define MRID_OP_SUB_ACC_FROM_FILE 6'h02
`define MRID_OP_DEC 6'h03
`define MRID_OP_IOR 6'h04
`define MRID_OP_AND 6'h05
`define MRID_OP_XOR 6'h06
`define MRID_OP_ADD_ACC_TO_FILE 6'h07
`define MRID_OP_MOVF 6'h08
`define MRID_OP_COM 6'h09
`define MRID_OP_INC 6'h0a
`define MRID_OP_DECSZ 6'h0b
`define MRID_OP_RR 6'h0c
`define MRID_OP_RL 6'h0d
`define MRID_OP_SWAP 6'h0e
`define MRID_OP_INCSZ 6'h0f

// ----------------------------------------------------------------
// bit-oriented opcodes, bits 11..10 under top bits 01
// ----------------------------------------------------------------
`define MRID_BIT_CLR 2'h0
`define MRID_BIT_SET 2'h1
`define MRID_BIT_TSC 2'h2
`define MRID_BIT_TSS 2'h3

// ----------------------------------------------------------------
// literal opcodes (top bits 11) and call/goto (top bits 10), upper bits of 13..8
// ----------------------------------------------------------------
`define MRID_LIT_IOR 6'h38
`define MRID_LIT_AND 6'h39
`define MRID_LIT_XOR 6'h3a
`define MRID_LIT_MOV_HI 4'hc
`define MRID_LIT_RET_HI 4'hd
`define MRID_LIT_SUB_HI 5'h1e
`define MRID_LIT_ADD_HI 5'h1f
`define MRID_CTL_CALL 3'h4
`define MRID_CTL_GOTO 3'h5

// ----------------------------------------------------------------
// full control words
// ----------------------------------------------------------------
`define MRID_W_RETFI 14'h0009
`define MRID_W_RET 14'h0008
`define MRID_W_SLEEP 14'h0063
`define MRID_W_WDTCLR 14'h0064

// ----------------------------------------------------------------
// special file addresses and reset values
// ----------------------------------------------------------------
`define MRID_FA_TMR 7'h01
`define MRID_FA_STATUS 7'h03
`define MRID_FA_PCL 7'h02
`define MRID_RST_VECTOR 13'h0000
`define MRID_PHASES 4
`define MRID_STACK_DEPTH 8

`endif

/* File: hdl/mrid_phase_gen.v */
// four-phase instruction cycle generator
`timescale 1ns/1ps
`include "mrid_defines.vh"
module mrid_phase_gen #(
  parameter PHASES = `MRID_PHASES
) (
  clk,
  nrst,
  cycle_end
);
  input wire clk;
  input wire nrst;
  output reg cycle_end;

  reg [1:0] phase_ff;

  // one instruction cycle is four oscillator periods
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= 2'h0;
      cycle_end <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 2'h1; // RL6
      cycle_end <= (phase_ff == PHASES - 2); // RL6
    end
  end
endmodule

/* File: hdl/mrid_alu.v */
// arithmetic and logic unit for the instruction decoder
`timescale 1ns/1ps
module mrid_alu (
  op,
  a,
  b,
  cin,
  res,
  cout,
  dcout
);
  input wire [3:0] op;
  input wire [7:0] a;
  input wire [7:0] b;
  input wire cin;
  output reg [7:0] res;
  output reg cout;
  output reg dcout;

  reg [8:0] sum;
  reg [4:0] lo;

  // op: 0 add, 1 sub b-a, 2 or, 3 and, 4 xor, 5 inv b, 6 inc b,
  // 7 dec b, 8 rl, 9 rr, a swap, b pass b, c pass a, d zero
  always @* begin
    sum = 9'h000;
    lo = 5'h00;
    res = 8'h00;
    cout = cin;
    dcout = 1'b0;
    case (op)
      4'h0: begin
        sum = {1'b0, a} + {1'b0, b};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res = sum[7:0];
        cout = sum[8];
        dcout = lo[4];
      end
      4'h1: begin
        // carry is not-borrow
        sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
        lo = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        res = sum[7:0];
        cout = sum[8];
        dcout = lo[4];
      end
      4'h2: res = a | b;
      4'h3: res = a & b;
      4'h4: res = a ^ b;
      4'h5: res = ~b;
      4'h6: res = b + 8'h01;
      4'h7: res = b - 8'h01;
      4'h8: begin
        res = {b[6:0], cin};
        cout = b[7];
      end
      4'h9: begin
        res = {cin, b[7:1]};
        cout = b[0];
      end
      4'ha: res = {b[3:0], b[7:4]};
      4'hb: res = b;
      4'hc: res = a;
      default: res = 8'h00;
    endcase
  end
endmodule

/* File: testbench/mrid_core_chk.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module mrid_core_chk #(
  parameter PCW = 13,
  parameter DEPTH = 8
) (
  input wire clk,
  input wire nrst,
  input wire [13:0] instr,
  input wire [1:0] pclath_hi,
  input wire [7:0] fr_rdata,
  input wire psa_to_timer,
  input wire [PCW-1:0] prog_addr,
  input wire [6:0] fr_addr,
  input wire fr_rd,
  input wire fr_wr,
  input wire [7:0] fr_wdata,
  input wire [7:0] acc,
  input wire carry_flag,
  input wire digit_carry_flag,
  input wire zero_flag,
  input wire timeout_flag,
  input wire power_down_flag,
  input wire prescaler_clr,
  input wire watchdog_clr,
  input wire standby,
  input wire irq_return
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_no_wr_rest;
    !fr_wr [*3];
  endsequence
  sequence s_pc_held;
    $stable(prog_addr) [*3];
  endsequence
  sequence s_wake_flags;
    ##[0:4] (timeout_flag && power_down_flag);
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_wr_once_per: assert property (fr_wr |=> s_no_wr_rest)
    else $error("file write repeated within one instruction cycle");
  a_wr_after_rd: assert property (fr_wr |->
    $past(fr_rd) || $past(fr_rd, 2) || $past(fr_rd, 3))
    else $error("file write without a preceding read");
  a_presc_psa: assert property (prescaler_clr |-> psa_to_timer)
    else $error("prescaler cleared while not assigned to timer");
  a_wdt_pulse: assert property (watchdog_clr |=> !watchdog_clr)
    else $error("watchdog clear longer than one clock");
  // standby entry also clears the watchdog but drops power-down
  a_wdt_flags: assert property ((watchdog_clr && !standby) |->
    s_wake_flags)
    else $error("watchdog clear did not set both flags");
  a_standby_flags: assert property ($rose(standby) |->
    ##[0:4] (!power_down_flag && timeout_flag))
    else $error("standby entry flags wrong");
  a_pc_four_clk: assert property ($changed(prog_addr) |=> s_pc_held)
    else $error("fetch address moved before four clocks");
  a_acc_boundary: assert property (
    $changed({acc, carry_flag, digit_carry_flag, zero_flag}) |->
    $changed(prog_addr))
    else $error("result changed off an instruction boundary");
endmodule

bind mrid_core mrid_core_chk #(.PCW(PCW), .DEPTH(DEPTH)) i_mrid_core_chk (
  .clk(clk), .nrst(nrst), .instr(instr), .pclath_hi(pclath_hi),
  .fr_rdata(fr_rdata), .psa_to_timer(psa_to_timer),
  .prog_addr(prog_addr), .fr_addr(fr_addr), .fr_rd(fr_rd),
  .fr_wr(fr_wr), .fr_wdata(fr_wdata), .acc(acc),
  .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
  .zero_flag(zero_flag), .timeout_flag(timeout_flag),
  .power_down_flag(power_down_flag), .prescaler_clr(prescaler_clr),
  .watchdog_clr(watchdog_clr), .standby(standby),
  .irq_return(irq_return));

/* File: testbench/mrid_prog_mem.sv */
// program memory and file register model facing the decoder
`timescale 1ns/1ps
module mrid_prog_mem (
  input wire clk,
  input wire [12:0] prog_addr,
  output wire [13:0] instr,
  input wire [6:0] fr_addr,
  input wire fr_rd,
  input wire fr_wr,
  input wire [7:0] fr_wdata,
  output wire [7:0] fr_rdata
);
  reg [13:0] pmem [0:255];
  reg [7:0] fmem [0:127];
  // one whole 14-bit word per fetch, answered at once
  assign instr = pmem[prog_addr[7:0]];
  // an unread bus shows the inverse so a stale value cannot pass
  assign fr_rdata = fr_rd ? fmem[fr_addr] : ~fmem[fr_addr];
  always @(posedge clk) begin
    if (fr_wr === 1'b1) begin
      fmem[fr_addr] <= fr_wdata;
    end
  end
  // unused space holds all-zero words, the no-operation form
  task clear;
    for (int i = 0; i < 256; i++) begin
      pmem[i] = 14'h0000;
    end
    for (int i = 0; i < 128; i++) begin
      fmem[i] = 8'h00;
    end
  endtask
endmodule

/* File: testbench/mrid_core_test.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, g, e); end end
module mrid_core_test;
  reg clk;
  reg nrst;
  reg [1:0] pclath_hi;
  reg psa_to_timer;
  wire [13:0] instr;
  wire [7:0] fr_rdata;
  wire [12:0] prog_addr;
  wire [6:0] fr_addr;
  wire fr_rd, fr_wr, carry_flag, digit_carry_flag, zero_flag;
  wire timeout_flag, power_down_flag, prescaler_clr, watchdog_clr;
  wire standby, irq_return;
  wire [7:0] fr_wdata;
  wire [7:0] acc;
  int error_cnt = 0;
  int tests_run = 0;
  int pa, wdc, psc, irc;
  mrid_core i_mrid_core (
    .clk(clk), .nrst(nrst), .instr(instr), .pclath_hi(pclath_hi),
    .fr_rdata(fr_rdata), .psa_to_timer(psa_to_timer),
    .prog_addr(prog_addr), .fr_addr(fr_addr), .fr_rd(fr_rd),
    .fr_wr(fr_wr), .fr_wdata(fr_wdata), .acc(acc),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag), .timeout_flag(timeout_flag),
    .power_down_flag(power_down_flag), .prescaler_clr(prescaler_clr),
    .watchdog_clr(watchdog_clr), .standby(standby),
    .irq_return(irq_return));
  mrid_prog_mem i_mrid_prog_mem (
    .clk(clk), .prog_addr(prog_addr), .instr(instr),
    .fr_addr(fr_addr), .fr_rd(fr_rd), .fr_wr(fr_wr),
    .fr_wdata(fr_wdata), .fr_rdata(fr_rdata));
  // ----------------------------------------------------------------
  // clock, pulse counters, tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (watchdog_clr === 1'b1) wdc++;
    if (prescaler_clr === 1'b1) psc++;
    if (irq_return === 1'b1) irc++;
  end
  task test_done;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hold reset for 20 clocks while the next program is loaded
  task start(input reg psa);
    @(posedge clk);
    nrst <= 1'b0;
    psa_to_timer <= psa;
    i_mrid_prog_mem.clear();
    pa = 0;
    repeat (20) @(posedge clk);
    wdc = 0;
    psc = 0;
    irc = 0;
  endtask
  task w(input reg [13:0] word);
    i_mrid_prog_mem.pmem[pa] = word;
    pa++;
  endtask
  // n counts slots, skipped ones and the flush slot included
  task go(input int n);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4 * n + 16) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic [7:0] fr(input int a);
    return i_mrid_prog_mem.fmem[a];
  endfunction
  initial begin
    #(100 * 4000);
    error_cnt++;
    test_done();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    pclath_hi = 2'h0;
    psa_to_timer = 1'b0;
    start(1'b0);
    `CHK({acc, carry_flag, digit_carry_flag, zero_flag}, 11'h000)
    `CHK({timeout_flag, power_down_flag}, 2'h3)
    `CHK(prog_addr, 13'h0000)
    // add literal with ignored low opcode bit, add to file, xor literal
    i_mrid_prog_mem.fmem[8'h20] = 8'h0f;
    w(14'h3f01);
    w(14'h07a0);
    w(14'h3a01);
    w(14'h0081);
    go(5);
    `CHK(acc, 8'h00)
    `CHK({carry_flag, digit_carry_flag, zero_flag}, 3'h3)
    `CHK(fr(8'h20), 8'h10)
    `CHK(psc, 0)
    // subtract from file, rotates through carry
    start(1'b0);
    i_mrid_prog_mem.fmem[8'h21] = 8'h05;
    w(14'h3803);
    w(14'h0221);
    w(14'h0da1);
    w(14'h0c21);
    go(5);
    `CHK(acc, 8'h05)
    `CHK({carry_flag, digit_carry_flag, zero_flag}, 3'h6)
    `CHK(fr(8'h21), 8'h0b)
    // skips: each skipped word would corrupt the accumulator
    start(1'b0);
    i_mrid_prog_mem.fmem[8'h22] = 8'h01;
    i_mrid_prog_mem.fmem[8'h23] = 8'h80;
    w(14'h0ba2);
    w(14'h38ff);
    w(14'h1fa3);
    w(14'h380f);
    w(14'h1823);
    w(14'h38f0);
    w(14'h1ba3);
    w(14'h3840);
    w(14'h14a3);
    w(14'h13a3);
    w(14'h0f22);
    go(15);
    `CHK(acc, 8'h01)
    `CHK(zero_flag, 1'b0)
    `CHK(fr(8'h22), 8'h00)
    `CHK(fr(8'h23), 8'h02)
    // complement, store, swap, and, inc, dec, clear, move
    start(1'b0);
    i_mrid_prog_mem.fmem[8'h24] = 8'h3c;
    i_mrid_prog_mem.fmem[8'h26] = 8'hff;
    w(14'h0924);
    w(14'h00a5);
    w(14'h0ea5);
    w(14'h0524);
    w(14'h0aa4);
    w(14'h0324);
    w(14'h01a6);
    w(14'h0824);
    w(14'h017f);
    go(10);
    `CHK({acc, zero_flag}, 9'h001)
    `CHK(fr(8'h24), 8'h3d)
    `CHK(fr(8'h25), 8'h3c)
    `CHK(fr(8'h26), 8'h00)
    // call, literal return, interrupt return; a word dropped after a return adds ff
    start(1'b0);
    pclath_hi <= 2'h1;
    w(14'h2005);
    w(14'h3e05);
    w(14'h2007);
    w(14'h3e10);
    w(14'h2804);
    w(14'h3421);
    w(14'h3eff);
    w(14'h0009);
    w(14'h3eff);
    go(12);
    `CHK(acc, 8'h36)
    `CHK(irc, 1)
    `CHK(prog_addr[12:11], 2'h1)
    // watchdog clear, timer write with prescaler assigned, standby
    start(1'b1);
    w(14'h0064);
    w(14'h0081);
    w(14'h0063);
    go(4);
    // watchdog clear and standby entry each clear the watchdog
    `CHK(wdc, 2)
    `CHK(psc, 1)
    `CHK({timeout_flag, power_down_flag, standby}, 3'h5)
    test_done();
  end
endmodule
